// ---- rtl/arir_pkg.sv ----
// Purpose: constants and helpers for the converter result and integrity register bank
// Assumes: APB register access, register byte address is four times the register index
package arir_pkg;

	// widths and counts
	localparam int DATA_W = 24;
	localparam int SHORT_W = 16;
	localparam int STATUS_W = 8;
	localparam int MODE_W = 16;
	localparam int USER_COUNT = 4;

	// register indices and byte addresses
	localparam logic [7:0] IDX_STATUS = 8'h00;
	localparam logic [7:0] IDX_MODE_CTRL = 8'h02;
	localparam logic [7:0] IDX_CHECKSUM = 8'h03;
	localparam logic [7:0] IDX_RESULT = 8'h04;
	localparam logic [11:0] ADDR_STATUS = {2'b00, IDX_STATUS, 2'b00};
	localparam logic [11:0] ADDR_MODE_CTRL = {2'b00, IDX_MODE_CTRL, 2'b00};
	localparam logic [11:0] ADDR_CHECKSUM = {2'b00, IDX_CHECKSUM, 2'b00};
	localparam logic [11:0] ADDR_RESULT = {2'b00, IDX_RESULT, 2'b00};

	// interface mode fields
	localparam int BIT_SHORT_WORD = 0;
	localparam int BIT_CRC_LO = 2;
	localparam int BIT_CRC_HI = 3;
	localparam int BIT_CHECK_EN = 5;
	localparam int BIT_APPEND = 6;
	localparam logic [15:0] MODE_CTRL_WMASK = 16'h006D;
	localparam logic [1:0] CRC_MODE_OFF = 2'b00;
	localparam logic [1:0] CRC_MODE_XOR = 2'b01;
	localparam logic [1:0] CRC_MODE_FULL = 2'b10;

	// status fields
	localparam int ST_READY_N = 7;
	localparam int ST_CRC_ERR = 5;
	localparam int ST_REG_ERR = 4;

	// reset values
	localparam logic [15:0] MODE_CTRL_RESET = 16'h0000;
	localparam logic [23:0] CHECKSUM_RESET = 24'h000000;
	localparam logic [23:0] RESULT_RESET = 24'h000000;
	localparam logic READY_N_RESET = 1'b1;

	// checksum polynomial x^8+x^2+x+1
	localparam logic [7:0] CRC_POLY = 8'h07;

	// crc-8 over register index and data word, msb first
	function automatic logic [7:0] arir_crc8(input logic [39:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 39; i >= 0; i--) begin
			if (c[7] ^ d[i]) begin
				c = {c[6:0], 1'b0} ^ CRC_POLY;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		return c;
	endfunction

	// byte-wise xor over register index and data word
	function automatic logic [7:0] arir_xor8(input logic [39:0] d);
		return d[39:32] ^ d[31:24] ^ d[23:16] ^ d[15:8] ^ d[7:0];
	endfunction

endpackage

// ---- rtl/arir_coder.sv ----
// Purpose: converts a raw filter result into the data register coding and length
// Assumes: raw is two's complement for bipolar setups, straight binary for unipolar
// Notes: purely combinational, captured by the register bank
`timescale 1ns/1ps
module arir_coder (
	input wire logic [arir_pkg::DATA_W-1:0] raw,
	input wire logic unipolar,
	input wire logic short_word,
	output logic [arir_pkg::DATA_W-1:0] coded
);
	import arir_pkg::*;

	logic [DATA_W-1:0] full_word;
	logic [SHORT_W:0] rounded;

	// coding choice, then rounding to the short word with saturation
	always_comb begin
		full_word = unipolar ? raw : {~raw[DATA_W-1], raw[DATA_W-2:0]};
		rounded = {1'b0, full_word[DATA_W-1:DATA_W-SHORT_W]} + {{SHORT_W{1'b0}}, full_word[DATA_W-SHORT_W-1]};
		if (rounded[SHORT_W]) begin
			rounded = {1'b0, {SHORT_W{1'b1}}};
		end
		if (short_word) begin
			coded = {{(DATA_W-SHORT_W){1'b0}}, rounded[SHORT_W-1:0]};
		end else begin
			coded = full_word;
		end
	end

endmodule

// ---- rtl/arir_regs.sv ----
// Purpose: result, checksum, status and interface mode registers behind an APB slave
// Assumes: result and user register inputs come from logic on pclk
// Notes: zero wait states; read data and check byte are registered in the setup cycle
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module arir_regs (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [7:0] pwcheck,
	output logic [31:0] prdata,
	output logic [7:0] prcheck,
	output logic pready,
	output logic pslverr,
	input wire logic result_valid,
	input wire logic [arir_pkg::DATA_W-1:0] result_raw,
	input wire logic [3:0] result_channel,
	input wire logic polarity_coding_select,
	input wire logic [arir_pkg::USER_COUNT*arir_pkg::DATA_W-1:0] user_regs,
	output logic ready_n,
	output logic [1:0] crc_mode,
	output logic reg_error
);
	import arir_pkg::*;

	logic [MODE_W-1:0] mode_ctrl_reg;
	logic [DATA_W-1:0] checksum_reg;
	logic [DATA_W-1:0] result_reg;
	logic result_short_reg;
	logic [3:0] result_chan_reg;
	logic ready_n_reg;
	logic crc_err_reg;
	logic reg_err_reg;
	logic [USER_COUNT*DATA_W-1:0] user_prev_reg;
	logic [31:0] prdata_reg;
	logic [7:0] prcheck_reg;
	logic err_reg;
	logic bad_write_reg;
	logic read_block_reg;

	logic short_word_select;
	logic check_en;
	logic append_status;
	logic setup;
	logic access;
	logic known;
	logic [31:0] rd_word;
	logic [STATUS_W-1:0] status_word;
	logic [7:0] read_crc;
	logic [7:0] read_xor;
	logic [7:0] write_crc;
	logic bad_write;
	logic read_cmd;
	logic take_result;
	logic [DATA_W-1:0] coded;
	logic [DATA_W-1:0] user_xor;

	// mode fields
	assign short_word_select = mode_ctrl_reg[BIT_SHORT_WORD];
	assign crc_mode = mode_ctrl_reg[BIT_CRC_HI:BIT_CRC_LO];
	assign check_en = mode_ctrl_reg[BIT_CHECK_EN];
	assign append_status = mode_ctrl_reg[BIT_APPEND];

	// bus phases and handshake
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign pready = 1'b1;
	assign pslverr = access & err_reg;
	assign prdata = prdata_reg;
	assign prcheck = prcheck_reg;
	assign ready_n = ready_n_reg;
	assign reg_error = reg_err_reg;

	assign status_word = {ready_n_reg, 1'b0, crc_err_reg, reg_err_reg, result_chan_reg};

	// read word selection by address
	always_comb begin
		known = 1'b1;
		rd_word = 32'h00000000;
		if (paddr == ADDR_STATUS) begin
			rd_word = {24'h000000, status_word};
		end else if (paddr == ADDR_MODE_CTRL) begin
			rd_word = {16'h0000, mode_ctrl_reg};
		end else if (paddr == ADDR_CHECKSUM) begin
			rd_word = {8'h00, checksum_reg};
		end else if (paddr == ADDR_RESULT) begin
			if (!append_status) begin
				rd_word = {8'h00, result_reg};
			end else if (result_short_reg) begin
				rd_word = {8'h00, status_word, result_reg[SHORT_W-1:0]};
			end else begin
				rd_word = {status_word, result_reg};
			end
		end else begin
			known = 1'b0;
		end
	end

	// check bytes for reads and the expected write checksum
	assign read_crc = arir_crc8({paddr[9:2], rd_word});
	assign read_xor = arir_xor8({paddr[9:2], rd_word});
	assign write_crc = arir_crc8({paddr[9:2], pwdata});
	assign bad_write = pwrite & (crc_mode != CRC_MODE_OFF) & (pwcheck != write_crc);

	// setup-cycle capture of answer, check byte and error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h00000000;
			prcheck_reg <= 8'h00;
			err_reg <= 1'b0;
			bad_write_reg <= 1'b0;
		end else if (setup) begin
			prdata_reg <= (pwrite || !known) ? 32'h00000000 : rd_word;
			if (pwrite || crc_mode == CRC_MODE_OFF) begin
				prcheck_reg <= 8'h00;
			end else if (crc_mode == CRC_MODE_XOR) begin
				prcheck_reg <= read_xor;
			end else begin
				prcheck_reg <= read_crc;
			end
			err_reg <= ~known | bad_write;
			bad_write_reg <= bad_write;
		end
	end

	// interface mode register, written unless crc_mode is not off and the check byte does not match
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ctrl_reg <= MODE_CTRL_RESET;
		end else if (access && pwrite && paddr == ADDR_MODE_CTRL && !err_reg) begin
			mode_ctrl_reg <= pwdata[MODE_W-1:0] & MODE_CTRL_WMASK;
		end
	end

	// read command to the result register holds off new results
	assign read_cmd = setup & ~pwrite & (paddr == ADDR_RESULT);
	assign take_result = result_valid & ~read_cmd & ~read_block_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			read_block_reg <= 1'b0;
		end else if (read_cmd) begin
			read_block_reg <= 1'b1;
		end else if (access) begin
			read_block_reg <= 1'b0;
		end
	end

	arir_coder u_coder (
		.raw(result_raw),
		.unipolar(polarity_coding_select),
		.short_word(short_word_select),
		.coded(coded)
	);

	// result capture with its length and channel; reading never destroys it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_reg <= RESULT_RESET;
			result_short_reg <= 1'b0;
			result_chan_reg <= 4'h0;
		end else if (take_result) begin
			result_reg <= coded;
			result_short_reg <= short_word_select;
			result_chan_reg <= result_channel;
		end
	end

	// ready goes low on a new result, high when the result is read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_n_reg <= READY_N_RESET;
		end else if (take_result) begin
			ready_n_reg <= 1'b0;
		end else if (access && read_block_reg) begin
			ready_n_reg <= 1'b1;
		end
	end

	// sticky write check error, cleared by a status read; a new error wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crc_err_reg <= 1'b0;
		end else if (access && bad_write_reg) begin
			crc_err_reg <= 1'b1;
		end else if (access && !pwrite && paddr == ADDR_STATUS) begin
			crc_err_reg <= 1'b0;
		end
	end

	// xor of the covered user registers
	always_comb begin
		user_xor = CHECKSUM_RESET;
		for (int i = 0; i < USER_COUNT; i++) begin
			user_xor = user_xor ^ user_regs[i*DATA_W +: DATA_W];
		end
	end

	// checksum register, zero while checking is off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			checksum_reg <= CHECKSUM_RESET;
		end else if (check_en) begin
			checksum_reg <= user_xor;
		end else begin
			checksum_reg <= CHECKSUM_RESET;
		end
	end

	// integrity error on any change of a covered register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			user_prev_reg <= '0;
			reg_err_reg <= 1'b0;
		end else begin
			user_prev_reg <= user_regs;
			if (!check_en) begin
				reg_err_reg <= 1'b0;
			end else if (user_regs != user_prev_reg) begin
				reg_err_reg <= 1'b1;
			end
		end
	end

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_result_read;
		read_cmd ##1 (access && !pwrite && paddr == ADDR_RESULT);
	endsequence

	a_crc_full_read: assert property (
		(setup && !pwrite && known && crc_mode == CRC_MODE_FULL) |=> prcheck == $past(read_crc))
		else $error("read crc byte wrong");

	a_xor_read_byte: assert property (
		(setup && !pwrite && known && crc_mode == CRC_MODE_XOR) |=> prcheck == $past(read_xor))
		else $error("read xor byte wrong");

	a_bad_write_refused: assert property (
		(setup && bad_write && paddr == ADDR_MODE_CTRL) ##1 access |=> $stable(mode_ctrl_reg) && crc_err_reg)
		else $error("bad write check not refused");

	a_short_word_width: assert property (
		(take_result && short_word_select) |=> result_reg[DATA_W-1:SHORT_W] == 8'h00 && result_short_reg)
		else $error("short result not sixteen bits");

	a_result_held: assert property (
		!take_result |=> $stable(result_reg) && $stable(result_short_reg))
		else $error("result changed without new conversion");

	a_checksum_value: assert property (
		check_en |=> checksum_reg == $past(user_xor))
		else $error("checksum not xor of user registers");

	a_checksum_off: assert property (
		!check_en |=> checksum_reg == CHECKSUM_RESET)
		else $error("checksum not zero while disabled");

	a_offset_coding: assert property (
		(take_result && !polarity_coding_select && !short_word_select) |=>
			result_reg[DATA_W-1] == !$past(result_raw[DATA_W-1]))
		else $error("offset binary sign bit wrong");

	a_read_sets_ready: assert property (
		s_result_read |=> ready_n && ready_n_reg)
		else $error("ready not high after result read");

	a_ready_stays_high: assert property (
		(ready_n_reg && !take_result) |=> ready_n_reg)
		else $error("ready fell without new result");

	a_read_blocks_update: assert property (
		read_cmd |=> $stable(result_reg) ##1 $stable(result_reg))
		else $error("result updated during result read");

	a_append_status: assert property (
		(read_cmd && append_status && !result_short_reg) |=> prdata[31:24] == $past(status_word))
		else $error("status byte not appended");

	a_append_off: assert property (
		(read_cmd && !append_status) |=> prdata[31:24] == 8'h00)
		else $error("status appended while disabled");

	a_reset_zero: assert property (@(posedge pclk) disable iff (1'b0)
		$rose(presetn) |-> result_reg == RESULT_RESET && checksum_reg == CHECKSUM_RESET)
		else $error("registers not zero after reset");

	a_integrity_error: assert property (
		(check_en && user_regs != user_prev_reg) |=> reg_err_reg [*1] ##1 (reg_err_reg || !$past(check_en)))
		else $error("integrity error not flagged");

	a_append_short: assert property (
		(read_cmd && append_status && result_short_reg) |=>
			prdata[31:24] == 8'h00 && prdata[23:16] == $past(status_word))
		else $error("status byte misplaced on short result");

	a_bad_write_slverr: assert property (
		(setup && bad_write) |=> pslverr)
		else $error("bad write check not signalled");

endmodule

// ---- tb/arir_host.sv ----
// Purpose: host side apb master for the result and integrity register bank
// Assumes: one transfer at a time, started from the bench
// Notes: always sends a crc check byte with a write, optionally spoiled
`timescale 1ns/1ps
module arir_host (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	output logic [7:0] pwcheck,
	input wire logic [31:0] prdata,
	input wire logic [7:0] prcheck,
	input wire logic pready,
	input wire logic pslverr
);
	// idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pwcheck = 8'h00;
	end

	// crc-8, poly 0x07, msb first, used by host and bench
	function automatic logic [7:0] host_crc8(input logic [39:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 39; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		end
		return c;
	endfunction

	// one setup and access cycle, held until pready is seen high or 20 cycles pass
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic bad,
		output logic [31:0] rd, output logic [7:0] rc, output logic err, output logic to);
		int n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		pwcheck <= host_crc8({a[9:2], wd}) ^ {7'h00, bad};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		rc = prcheck;
		err = pslverr;
		to = (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

// ---- tb/adc_result_and_integrity_regs_tb_top.sv ----
// Purpose: self-checking bench for the result and integrity register bank
// Assumes: zero wait apb slave, results coded at capture
// Notes: table of plain register accesses, then hand-written result and check cases
`timescale 1ns/1ps
module adc_result_and_integrity_regs_tb_top;
	import arir_pkg::*;
	typedef struct packed {logic wr; logic [11:0] a; logic [31:0] wd; logic [31:0] exp; logic err;} arir_row_t;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, ready_n, reg_error, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] pwcheck, prcheck, rc;
	logic [1:0] crc_mode;
	logic result_valid = 1'b0;
	logic polarity_coding_select = 1'b0;
	logic [23:0] result_raw = 24'h0;
	logic [3:0] result_channel = 4'h5;
	logic [95:0] user_regs = {24'h001000, 24'h000100, 24'h000010, 24'h000001};
	int n_errors = 0;
	int checks_done = 0;
	arir_row_t rows [11] = '{
		'{1'b0, ADDR_CHECKSUM, 32'h0, 32'h0, 1'b0}, '{1'b0, ADDR_RESULT, 32'h0, 32'h0, 1'b0},
		'{1'b1, ADDR_CHECKSUM, 32'hFFFFFF, 32'h0, 1'b0}, '{1'b1, ADDR_RESULT, 32'hFFFFFF, 32'h0, 1'b0},
		'{1'b0, ADDR_CHECKSUM, 32'h0, 32'h0, 1'b0}, '{1'b0, ADDR_RESULT, 32'h0, 32'h0, 1'b0},
		'{1'b0, 12'h014, 32'h0, 32'h0, 1'b1}, '{1'b1, ADDR_MODE_CTRL, 32'h20, 32'h0, 1'b0},
		'{1'b0, ADDR_CHECKSUM, 32'h0, 32'h001111, 1'b0}, '{1'b1, ADDR_MODE_CTRL, 32'h0, 32'h0, 1'b0},
		'{1'b0, ADDR_CHECKSUM, 32'h0, 32'h0, 1'b0}};

	// clock
	always #25 pclk = ~pclk;

	arir_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pwcheck(pwcheck), .prdata(prdata), .prcheck(prcheck),
		.pready(pready), .pslverr(pslverr), .result_valid(result_valid), .result_raw(result_raw),
		.result_channel(result_channel), .polarity_coding_select(polarity_coding_select),
		.user_regs(user_regs), .ready_n(ready_n), .crc_mode(crc_mode), .reg_error(reg_error));
	arir_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pwcheck(pwcheck), .prdata(prdata), .prcheck(prcheck), .pready(pready),
		.pslverr(pslverr));

	// compare and count
	task automatic check(input logic [39:0] seen, input logic [39:0] want);
		checks_done++;
		if (seen !== want) begin
			n_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	// verdict and stop
	task automatic end_sim;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// one bus transfer, a hung bus ends the run
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic bad);
		logic to;
		u_host.xfer(wr, a, wd, bad, rd, rc, er, to);
		if (to) begin
			n_errors++;
			end_sim();
		end
	endtask

	// read and compare the word
	task automatic rchk(input logic [11:0] a, input logic [31:0] want);
		bus(1'b0, a, 32'h0, 1'b0);
		check(rd, want);
	endtask

	// one-cycle conversion result pulse
	task automatic pulse(input logic [23:0] v, input logic pol);
		@(posedge pclk);
		result_valid <= 1'b1;
		result_raw <= v;
		polarity_coding_select <= pol;
		@(posedge pclk);
		result_valid <= 1'b0;
	endtask

	// main sequence
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		check({ready_n, crc_mode, reg_error, prdata}, {4'b1000, 32'h0});
		foreach (rows[i]) begin
			bus(rows[i].wr, rows[i].a, rows[i].wd, 1'b0);
			check({rd, 7'h00, er}, {rows[i].exp, 7'h00, rows[i].err});
		end
		bus(1'b1, ADDR_MODE_CTRL, 32'h40, 1'b0);
		pulse(24'h000010, 1'b0);
		@(negedge pclk);
		check(ready_n, 1'b0);
		rchk(ADDR_RESULT, 32'h05800010);
		@(negedge pclk);
		check(ready_n, 1'b1);
		fork
			rchk(ADDR_RESULT, 32'h85800010);
			pulse(24'h000020, 1'b0);
		join
		@(negedge pclk);
		check(ready_n, 1'b1);
		rchk(ADDR_RESULT, 32'h85800010);
		pulse(24'h000030, 1'b1);
		rchk(ADDR_RESULT, 32'h05000030);
		bus(1'b1, ADDR_MODE_CTRL, 32'h41, 1'b0);
		rchk(ADDR_RESULT, 32'h85000030);
		pulse(24'h123480, 1'b0);
		rchk(ADDR_RESULT, 32'h00059235);
		bus(1'b1, ADDR_MODE_CTRL, 32'h08, 1'b0);
		@(negedge pclk);
		check(crc_mode, CRC_MODE_FULL);
		rchk(ADDR_RESULT, 32'h00009235);
		check(rc, u_host.host_crc8({IDX_RESULT, 32'h00009235}));
		bus(1'b1, ADDR_MODE_CTRL, 32'h04, 1'b1);
		@(negedge pclk);
		check({er, crc_mode}, {1'b1, CRC_MODE_FULL});
		rchk(ADDR_STATUS, 32'h000000A5);
		rchk(ADDR_STATUS, 32'h00000085);
		bus(1'b1, ADDR_MODE_CTRL, 32'h04, 1'b0);
		@(negedge pclk);
		check({er, crc_mode}, {1'b0, CRC_MODE_XOR});
		rchk(ADDR_RESULT, 32'h00009235);
		check(rc, IDX_RESULT ^ 8'h92 ^ 8'h35);
		bus(1'b1, ADDR_MODE_CTRL, 32'h20, 1'b0);
		@(posedge pclk);
		user_regs[23:0] <= 24'h000002;
		repeat (3) @(negedge pclk);
		check(reg_error, 1'b1);
		bus(1'b1, ADDR_MODE_CTRL, 32'h00, 1'b0);
		repeat (2) @(negedge pclk);
		check(reg_error, 1'b0);
		end_sim();
	end
endmodule
